/* twc_config_port.sv */
// Three-wire serial configuration port with startup and command control
`timescale 1ns/10ps
module twc_config_port
	import twc_pkg::*;
#(
	parameter int unsigned POWER_UP_CYCLES = PUP_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Serial port pins
	input wire logic sclk,
	input wire logic select_n,
	input wire logic serial_data_in,
	output logic serial_data_out,
	output logic serial_data_oe,
	// Strap and reference input
	input wire logic divider_default_strap,
	input wire logic ref_in,
	// Completion reports from the analog side
	input wire logic align_done,
	input wire logic bias_cal_done,
	input wire logic delay_cal_done,
	input wire logic init_done,
	// Startup and command control
	output logic power_up_done,
	output logic clk_input_enable,
	output logic align_start,
	output logic bias_cal_start,
	output logic delay_cal_start,
	output logic outputs_hold_low,
	// Configuration towards the datapath
	output logic [7:0] clock_output_enable,
	output logic [7:0] sysref_output_enable,
	output logic [3:0] channel_b_divider,
	output logic [3:0] channel_c_divider
);
	logic [7:0] regs [REG_COUNT];
	twc_state_t state;
	logic sclk_q, ref_q;
	logic [2:0] bit_cnt;
	logic [7:0] shreg;
	logic [6:0] spi_addr;
	logic [7:0] tx_reg;
	logic [2:0] tx_cnt;
	logic [31:0] pup_cnt;
	logic strap_taken, align_busy;
	logic sclk_rise, sclk_fall;
	logic read_edge_select, init_clk_cmd;
	logic multi_device_align_cmd, bias_calibrate_cmd, delay_calibrate_cmd;
	logic [7:0] next_byte;
	twc_cmd_t cmd;
	logic cmd_done, emit;
	logic [6:0] emit_addr;
	logic [7:0] emit_src;
	twc_wr_t wr;

	// Register readback, status and unused space overlaid
	function automatic logic [7:0] read_value(input logic [6:0] a);
		logic [7:0] v;
		v = regs[a];
		if (a == ADDR_POWER_UP_STATUS) begin
			v = RST_ZERO;
			v[BIT_POWER_UP_DONE] = power_up_done;
		end else if (a >= ADDR_FIRST_UNUSED) begin
			v = RST_ZERO;
		end
		return v;
	endfunction

	// Named control bits out of the register file
	assign read_edge_select = regs[ADDR_GEN_CTRL][BIT_READ_EDGE];
	assign multi_device_align_cmd = regs[ADDR_CTRL][BIT_ALIGN];
	assign bias_calibrate_cmd = regs[ADDR_CTRL][BIT_BIAS_CAL];
	assign delay_calibrate_cmd = regs[ADDR_CTRL][BIT_DELAY_CAL];
	assign init_clk_cmd = regs[ADDR_CTRL][BIT_INIT_CLK];
	assign clock_output_enable = regs[ADDR_CLOCK_OUTPUT_ENABLES];
	assign sysref_output_enable = regs[ADDR_SYSREF_OUTPUT_ENABLES];
	assign channel_b_divider = regs[ADDR_DIV_B][3:0];
	assign channel_c_divider = regs[ADDR_DIV_C][3:0];

	// Edge detection on the sampled serial clock and reference
	assign sclk_rise = sclk && !sclk_q && !select_n;
	assign sclk_fall = !sclk && sclk_q && !select_n;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sclk_q <= 1'b0;
			ref_q <= 1'b0;
		end else begin
			sclk_q <= sclk;
			ref_q <= ref_in;
		end
	end

	// Byte assembly, least significant bit arrives first
	always_comb begin
		next_byte = {serial_data_in, shreg[7:1]};
		cmd = twc_cmd_t'(next_byte);
		cmd_done = (state == st_command) && sclk_rise && (bit_cnt == 3'h7);
		wr = '0;
		if ((state == st_write) && sclk_rise && (bit_cnt == 3'h7)) begin
			wr.en = (spi_addr != ADDR_POWER_UP_STATUS)
				&& (spi_addr < ADDR_FIRST_UNUSED);
			wr.addr = spi_addr;
			wr.data = next_byte;
		end
	end

	// Read shifting: first bit on the command edge when edge select is 1
	always_comb begin
		emit = ((state == st_read) && (read_edge_select ? sclk_rise
			: sclk_fall)) || (cmd_done && cmd.dir && read_edge_select);
		emit_addr = cmd_done ? cmd.addr : spi_addr;
		emit_src = (tx_cnt == 3'h0) ? read_value(emit_addr) : tx_reg;
	end

	// Serial state machine
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state <= st_idle;
			bit_cnt <= 3'h0;
			shreg <= RST_ZERO;
			spi_addr <= 7'h00;
			tx_reg <= RST_ZERO;
			tx_cnt <= 3'h0;
		end else if (select_n) begin
			state <= st_idle;
			bit_cnt <= 3'h0;
			tx_cnt <= 3'h0;
		end else begin
			case (state)
				st_idle: begin
					state <= st_command;
				end
				st_command: begin
					if (sclk_rise) begin
						shreg <= next_byte;
						bit_cnt <= bit_cnt + 3'h1;
					end
					if (cmd_done) begin
						spi_addr <= cmd.addr;
						state <= cmd.dir ? st_read : st_write;
					end
				end
				st_write: begin
					if (sclk_rise) begin
						shreg <= next_byte;
						bit_cnt <= bit_cnt + 3'h1;
					end
					if (sclk_rise && bit_cnt == 3'h7) begin
						spi_addr <= spi_addr + 7'h01;
					end
				end
				st_read: begin
				end
				default: begin
					state <= st_idle;
				end
			endcase
			if (emit) begin
				tx_reg <= {1'b0, emit_src[7:1]};
				tx_cnt <= tx_cnt + 3'h1;
				if (tx_cnt == 3'h7) begin
					spi_addr <= emit_addr + 7'h01;
				end
			end
		end
	end

	// Data line driver, input mode while idle or selected off
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			serial_data_out <= 1'b0;
			serial_data_oe <= 1'b0;
		end else if (select_n || state == st_idle) begin
			serial_data_oe <= 1'b0;
			serial_data_out <= 1'b0;
		end else begin
			if (cmd_done && cmd.dir) begin
				serial_data_oe <= 1'b1;
			end
			if (emit) begin
				serial_data_out <= emit_src[0];
			end
		end
	end

	// Power-up timer gating the clock input
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pup_cnt <= 32'h0;
			power_up_done <= 1'b0;
			clk_input_enable <= 1'b0;
		end else if (!power_up_done) begin
			if (pup_cnt == POWER_UP_CYCLES - 1) begin
				power_up_done <= 1'b1;
				clk_input_enable <= 1'b1;
			end else begin
				pup_cnt <= pup_cnt + 32'h1;
			end
		end
	end

	// Register file; the software write comes last so a set beats a clear
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				regs[i] <= RST_ZERO;
			end
			regs[ADDR_DIV_B] <= RST_DIV_BC;
			regs[ADDR_DIV_C] <= RST_DIV_BC;
			regs[ADDR_CLOCK_OUTPUT_ENABLES] <= RST_CLOCK_OUTPUT_ENABLES;
			regs[ADDR_SYSREF_OUTPUT_ENABLES] <= RST_SYSREF_OUTPUT_ENABLES;
			strap_taken <= 1'b0;
		end else begin
			if (!strap_taken) begin
				strap_taken <= 1'b1;
				regs[ADDR_DIV_B][BIT_STRAP] <= divider_default_strap;
				regs[ADDR_DIV_C][BIT_STRAP] <= divider_default_strap;
			end
			if (align_done && align_busy) begin
				regs[ADDR_CTRL][BIT_ALIGN] <= 1'b0;
			end
			if (bias_cal_done) begin
				regs[ADDR_CTRL][BIT_BIAS_CAL] <= 1'b0;
			end
			if (delay_cal_done) begin
				regs[ADDR_CTRL][BIT_DELAY_CAL] <= 1'b0;
			end
			if (init_done) begin
				regs[ADDR_CTRL][BIT_INIT_CLK] <= 1'b0;
			end
			// Sysref delay writes just store; no output stop, no init needed
			if (wr.en) begin
				regs[wr.addr] <= wr.data;
			end
		end
	end

	// Command launch pulses and output hold during init
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			bias_cal_start <= 1'b0;
			delay_cal_start <= 1'b0;
			outputs_hold_low <= 1'b0;
		end else begin
			bias_cal_start <= wr.en && (wr.addr == ADDR_CTRL)
				&& wr.data[BIT_BIAS_CAL];
			delay_cal_start <= wr.en && (wr.addr == ADDR_CTRL)
				&& wr.data[BIT_DELAY_CAL];
			outputs_hold_low <= init_clk_cmd;
		end
	end

	// Alignment waits for a reference rising edge while armed
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			align_start <= 1'b0;
			align_busy <= 1'b0;
		end else begin
			align_start <= 1'b0;
			if (multi_device_align_cmd && !align_busy && ref_in && !ref_q) begin
				align_start <= 1'b1;
				align_busy <= 1'b1;
			end else if (align_done || !multi_device_align_cmd) begin
				align_busy <= 1'b0;
			end
		end
	end

	property p_line_released;
		@(posedge clk_sys) disable iff (rst)
		select_n |=> !serial_data_oe;
	endproperty
	a_line_released: assert property (p_line_released)
		else $error("data line driven while select high");

	property p_read_turnaround;
		@(posedge clk_sys) disable iff (rst)
		(cmd_done && cmd.dir) ##1 !select_n |-> serial_data_oe;
	endproperty
	a_read_turnaround: assert property (p_read_turnaround)
		else $error("data line not driven after read command");

	property p_write_commit;
		@(posedge clk_sys) disable iff (rst)
		wr.en && wr.addr == ADDR_CLOCK_OUTPUT_ENABLES
		|=> clock_output_enable == $past(wr.data);
	endproperty
	a_write_commit: assert property (p_write_commit)
		else $error("write byte not committed");

	property p_write_increment;
		@(posedge clk_sys) disable iff (rst)
		wr.en |=> spi_addr == $past(spi_addr) + 7'h01;
	endproperty
	a_write_increment: assert property (p_write_increment)
		else $error("write address did not advance");

	property p_bias_start;
		@(posedge clk_sys) disable iff (rst)
		wr.en && wr.addr == ADDR_CTRL && wr.data[BIT_BIAS_CAL]
		|=> bias_cal_start && bias_calibrate_cmd;
	endproperty
	a_bias_start: assert property (p_bias_start)
		else $error("bias calibration not started");

	property p_bias_clear;
		@(posedge clk_sys) disable iff (rst)
		bias_cal_done && !(wr.en && wr.addr == ADDR_CTRL)
		|=> !bias_calibrate_cmd;
	endproperty
	a_bias_clear: assert property (p_bias_clear)
		else $error("bias command did not self-clear");

	property p_align_cause;
		@(posedge clk_sys) disable iff (rst)
		align_start |-> $past(multi_device_align_cmd) && $past(ref_in)
			&& !$past(ref_q);
	endproperty
	a_align_cause: assert property (p_align_cause)
		else $error("alignment started without armed reference edge");

	property p_startup_defaults;
		@(posedge clk_sys) disable iff (rst)
		$rose(strap_taken) |-> clock_output_enable == RST_CLOCK_OUTPUT_ENABLES
			&& sysref_output_enable == RST_SYSREF_OUTPUT_ENABLES
			&& channel_b_divider[BIT_STRAP] == $past(divider_default_strap);
	endproperty
	a_startup_defaults: assert property (p_startup_defaults)
		else $error("startup defaults wrong");

	property p_clock_gate;
		@(posedge clk_sys) disable iff (rst)
		!power_up_done |-> !clk_input_enable && pup_cnt < POWER_UP_CYCLES;
	endproperty
	a_clock_gate: assert property (p_clock_gate)
		else $error("clock input enabled before power-up end");
endmodule

/* twc_config_port_bench.sv */
// Self-checking bench for the three-wire configuration port
`timescale 1ns/10ps
module twc_config_port_bench;
	import twc_pkg::*;
	localparam int unsigned PUP = 20;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic sclk, select_n, serial_data_in, serial_data_out, serial_data_oe;
	logic divider_default_strap = 1'b1;
	logic ref_in = 1'b0;
	logic align_done = 1'b0;
	logic bias_cal_done = 1'b0;
	logic delay_cal_done = 1'b0;
	logic init_done = 1'b0;
	logic power_up_done, clk_input_enable, align_start;
	logic bias_cal_start, delay_cal_start, outputs_hold_low;
	logic [7:0] clock_output_enable, sysref_output_enable;
	logic [3:0] channel_b_divider, channel_c_divider;
	logic [7:0] q;
	int n_errors = 0;
	int checks = 0;
	int cyc = 0;
	int n_align = 0;
	int n_bias = 0;
	int n_delay = 0;

	twc_config_port #(.POWER_UP_CYCLES(PUP)) twc_config_port_i (
		.clk_sys, .rst, .sclk, .select_n, .serial_data_in,
		.serial_data_out, .serial_data_oe, .divider_default_strap,
		.ref_in, .align_done, .bias_cal_done, .delay_cal_done,
		.init_done, .power_up_done, .clk_input_enable, .align_start,
		.bias_cal_start, .delay_cal_start, .outputs_hold_low,
		.clock_output_enable, .sysref_output_enable,
		.channel_b_divider, .channel_c_divider);
	twc_master_model twc_master_model_i (
		.clk_sys, .sclk, .select_n, .serial_data_in,
		.serial_data_out, .serial_data_oe);

	// System clock
	initial begin
		forever #10 clk_sys = ~clk_sys;
	end
	// Start pulse counts and the run-time ceiling
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (align_start === 1'b1) n_align <= n_align + 1;
		if (bias_cal_start === 1'b1) n_bias <= n_bias + 1;
		if (delay_cal_start === 1'b1) n_delay <= n_delay + 1;
		if (cyc == 20000) begin
			n_errors = n_errors + 1;
			$display("[ERR] %0t run ceiling reached", $time);
			report_and_stop();
		end
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e,
		input string w);
		checks = checks + 1;
		if (g !== e) begin
			n_errors = n_errors + 1;
			$display("[ERR] %0t %s got %h exp %h", $time, w, g, e);
		end
	endtask
	task automatic rchk(input logic [6:0] a, input logic [7:0] e,
		input string w);
		logic [7:0] d;
		twc_master_model_i.rd(a, d);
		chk(d, e, w);
	endtask
	// One-cycle completion report: 0 align, 1 bias, 2 delay, 3 init
	task automatic pulse(input int which);
		align_done <= (which == 0);
		bias_cal_done <= (which == 1);
		delay_cal_done <= (which == 2);
		init_done <= (which == 3);
		@(posedge clk_sys);
		align_done <= 1'b0;
		bias_cal_done <= 1'b0;
		delay_cal_done <= 1'b0;
		init_done <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask
	// Defaults, strap divider and power-up timing
	task automatic t_reset();
		logic [7:0] d;
		d = 8'h00;
		repeat (10) @(posedge clk_sys);
		chk(8'(channel_b_divider), 8'h03, "div b");
		chk(8'(channel_c_divider), 8'h03, "div c");
		chk(clock_output_enable, 8'hFF, "clk en");
		chk(sysref_output_enable, 8'h00, "ref en");
		chk(8'(power_up_done), 8'h00, "early ready");
		chk(8'(clk_input_enable), 8'h00, "early clk in");
		repeat (15) @(posedge clk_sys);
		chk(8'(clk_input_enable), 8'h01, "clk in");
		for (int i = 0; i < 5 && d[1] !== 1'b1; i++) begin
			twc_master_model_i.rd(ADDR_POWER_UP_STATUS, d);
		end
		chk(d, 8'h02, "status");
		$display("reset test done");
	endtask
	// Burst write then burst read across three registers
	task automatic t_burst();
		twc_master_model_i.open_frame();
		twc_master_model_i.byte_io({7'h74, 1'b0}, 1'b0, q);
		twc_master_model_i.byte_io(8'hA5, 1'b0, q);
		twc_master_model_i.byte_io(8'h3C, 1'b0, q);
		twc_master_model_i.byte_io(8'h5A, 1'b0, q);
		twc_master_model_i.close_frame();
		chk(clock_output_enable, 8'hA5, "clk en wr");
		chk(sysref_output_enable, 8'h5A, "ref en wr");
		twc_master_model_i.open_frame();
		twc_master_model_i.byte_io({7'h74, 1'b1}, 1'b1, q);
		twc_master_model_i.byte_io(8'h00, 1'b0, q);
		chk(q, 8'hA5, "burst 0");
		twc_master_model_i.byte_io(8'h00, 1'b0, q);
		chk(q, 8'h3C, "burst 1");
		twc_master_model_i.byte_io(8'h00, 1'b0, q);
		chk(q, 8'h5A, "burst 2");
		twc_master_model_i.close_frame();
		chk(8'(serial_data_oe), 8'h00, "line idle");
		$display("burst test done");
	endtask
	// Rising-edge read mode and a read-only register
	task automatic t_edge();
		twc_master_model_i.wr(ADDR_GEN_CTRL, 8'h01);
		rchk(7'h74, 8'hA5, "edge1 read");
		twc_master_model_i.wr(ADDR_GEN_CTRL, 8'h00);
		rchk(7'h76, 8'h5A, "edge0 read");
		twc_master_model_i.wr(ADDR_POWER_UP_STATUS, 8'hFF);
		rchk(ADDR_POWER_UP_STATUS, 8'h02, "ro status");
		$display("edge test done");
	endtask
	// Calibration commands pend, start once and self-clear
	task automatic t_cal();
		twc_master_model_i.wr(ADDR_CTRL, 8'h06);
		rchk(ADDR_CTRL, 8'h06, "cal pend");
		chk(8'(n_bias), 8'h01, "bias start");
		chk(8'(n_delay), 8'h01, "delay start");
		pulse(1);
		rchk(ADDR_CTRL, 8'h04, "bias clr");
		pulse(2);
		rchk(ADDR_CTRL, 8'h00, "delay clr");
		$display("cal test done");
	endtask
	// Alignment waits for the reference edge; init holds outputs low
	task automatic t_align_init();
		twc_master_model_i.wr(ADDR_CTRL, 8'h01);
		repeat (10) @(posedge clk_sys);
		chk(8'(n_align), 8'h00, "align early");
		ref_in <= 1'b1;
		repeat (3) @(posedge clk_sys);
		ref_in <= 1'b0;
		chk(8'(n_align), 8'h01, "align start");
		rchk(ADDR_CTRL, 8'h01, "align pend");
		pulse(0);
		rchk(ADDR_CTRL, 8'h00, "align clr");
		twc_master_model_i.wr(ADDR_CTRL, 8'h08);
		repeat (2) @(posedge clk_sys);
		chk(8'(outputs_hold_low), 8'h01, "hold low");
		pulse(3);
		chk(8'(outputs_hold_low), 8'h00, "hold end");
		rchk(ADDR_CTRL, 8'h00, "init clr");
		$display("align and init test done");
	endtask
	// Fresh reset with the strap low picks the other divider default
	task automatic t_strap();
		divider_default_strap <= 1'b0;
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk(8'(channel_b_divider), 8'h02, "div b low");
		chk(8'(channel_c_divider), 8'h02, "div c low");
		chk(clock_output_enable, 8'hFF, "clk en again");
		chk(sysref_output_enable, 8'h00, "ref en again");
		chk(8'(power_up_done), 8'h00, "ready again");
		rchk(7'h74, 8'hFF, "clk en read");
		$display("strap test done");
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		t_reset();
		t_burst();
		t_edge();
		t_cal();
		t_align_init();
		t_strap();
		report_and_stop();
	end
endmodule

/* twc_master_model.sv */
// Behavioural serial master driving the three-wire configuration port
`timescale 1ns/10ps
module twc_master_model (
	// System clock
	input wire logic clk_sys,
	// Serial pins
	output logic sclk,
	output logic select_n,
	output logic serial_data_in,
	input wire logic serial_data_out,
	input wire logic serial_data_oe
);
	logic m_oe = 1'b0;
	logic m_bit = 1'b0;
	logic last = 1'b0;
	initial sclk = 1'b0;
	initial select_n = 1'b1;
	// Wire level; an undriven line toggles so a stale bit never passes
	assign serial_data_in = serial_data_oe ? serial_data_out :
		(m_oe ? m_bit : ~last);
	always @(posedge clk_sys) last <= serial_data_in;
	// One serial clock period: data set while low, sampled before the rise
	task automatic bit_io(input logic b, input logic rel, output logic q);
		sclk <= 1'b0;
		m_bit <= b;
		repeat (4) @(posedge clk_sys);
		q = serial_data_in;
		sclk <= 1'b1;
		repeat (2) @(posedge clk_sys);
		if (rel) m_oe <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask
	// Whole byte, least significant bit first; rel frees the line after it
	task automatic byte_io(input logic [7:0] v, input logic rel,
		output logic [7:0] q);
		for (int i = 0; i < 8; i++) begin
			bit_io(v[i], rel && i == 7, q[i]);
		end
	endtask
	// Select falls well ahead of the first rise
	task automatic open_frame();
		select_n <= 1'b0;
		m_oe <= 1'b1;
		repeat (4) @(posedge clk_sys);
	endtask
	// Select rises only after whole bytes; clock stands low meanwhile
	task automatic close_frame();
		sclk <= 1'b0;
		repeat (4) @(posedge clk_sys);
		select_n <= 1'b1;
		m_oe <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask
	// Single-byte write; addresses above 0x77 are never used
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] q;
		open_frame();
		byte_io({a, 1'b0}, 1'b0, q);
		byte_io(d, 1'b0, q);
		close_frame();
	endtask
	// Single-byte read; line released for the answer
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		open_frame();
		byte_io({a, 1'b1}, 1'b1, d);
		byte_io(8'h00, 1'b0, d);
		close_frame();
	endtask
endmodule

/* twc_pkg.sv */
// Constants, types and register map of the three-wire configuration port
package twc_pkg;
	// Clock and power-up timing
	localparam int unsigned CLK_FREQ_HZ = 50000000;
	localparam int unsigned PUP_TIME_MS = 2;
	localparam int unsigned PUP_CYCLES = PUP_TIME_MS * (CLK_FREQ_HZ / 1000);
	// Register space
	localparam int unsigned REG_COUNT = 128;
	localparam logic [6:0] ADDR_FIRST_UNUSED = 7'h78;
	localparam logic [6:0] ADDR_CTRL = 7'h18;
	localparam logic [6:0] ADDR_DIV_A = 7'h20;
	localparam logic [6:0] ADDR_DIV_B = 7'h30;
	localparam logic [6:0] ADDR_DIV_C = 7'h40;
	localparam logic [6:0] ADDR_DIV_D = 7'h50;
	localparam logic [6:0] ADDR_GEN_CTRL = 7'h6C;
	localparam logic [6:0] ADDR_POWER_UP_STATUS = 7'h6E;
	localparam logic [6:0] ADDR_CLOCK_OUTPUT_ENABLES = 7'h74;
	localparam logic [6:0] ADDR_SYSREF_OUTPUT_ENABLES = 7'h76;
	// Field positions
	localparam int unsigned BIT_ALIGN = 0;
	localparam int unsigned BIT_BIAS_CAL = 1;
	localparam int unsigned BIT_DELAY_CAL = 2;
	localparam int unsigned BIT_INIT_CLK = 3;
	localparam int unsigned BIT_READ_EDGE = 0;
	localparam int unsigned BIT_POWER_UP_DONE = 1;
	localparam int unsigned BIT_STRAP = 0;
	// Reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_DIV_BC = 8'h02;
	localparam logic [7:0] RST_CLOCK_OUTPUT_ENABLES = 8'hFF;
	localparam logic [7:0] RST_SYSREF_OUTPUT_ENABLES = 8'h00;
	// First byte of a transfer, as received least significant bit first
	typedef struct packed {
		logic [6:0] addr;
		logic dir;
	} twc_cmd_t;
	// One register write towards the register file
	typedef struct packed {
		logic en;
		logic [6:0] addr;
		logic [7:0] data;
	} twc_wr_t;
	typedef enum logic [1:0] {
		st_idle,
		st_command,
		st_write,
		st_read
	} twc_state_t;
endpackage
